/* common/tsfc_regs.svh */
// constants for the terminal setup and flow control block
`ifndef TSFC_REGS_SVH
`define TSFC_REGS_SVH
// clock and timing
`define TSFC_CLK_HZ        25000000
`define TSFC_RPT_DELAY_MS  500
`define TSFC_RPT_RATE_CPS  30
`define TSFC_WAIT_CYC      16
// register offsets and fields
`define TSFC_OFF_CTRL      8'h00
`define TSFC_OFF_STATUS    8'h04
`define TSFC_F_AXON        0
`define TSFC_F_AREP        1
`define TSFC_F_EIGHT       2
`define TSFC_C_WIDE        3
`define TSFC_C_ONLINE      4
// key codes from the keyboard scanner
`define TSFC_K_SETUP       8'h80
`define TSFC_K_LEFT        8'h81
`define TSFC_K_RIGHT       8'h82
`define TSFC_K_UP          8'h83
`define TSFC_K_DOWN        8'h84
`define TSFC_K_NOSCROLL    8'h85
`define TSFC_K_BREAK       8'h86
`define TSFC_K_TAB         8'h09
`define TSFC_K_RET         8'h0D
`define TSFC_K_ESC         8'h1B
`define TSFC_K_SPACE       8'h20
// link codes and limits
`define TSFC_XON           8'h11
`define TSFC_XOFF          8'h13
`define TSFC_ENQ           8'h05
`define TSFC_GLYPH         8'hB0
`define TSFC_MSG_MAX       5'd20
`define TSFC_RX_NEAR_FULL  8'd48
`define TSFC_COLS_N        8'd80
`define TSFC_COLS_W        8'd132
`define TSFC_ROWS_F        5'd24
`define TSFC_ROWS_W        5'd14
// reset values
`define TSFC_RST_BRIGHT    4'h8
`define TSFC_RST_SPEED     4'hE
`endif

/* common/tsfc_pkg.sv */
// types for the terminal setup and flow control block
package tsfc_pkg;
  typedef enum logic [2:0] {M_OFF, M_SETUP, M_DELIM, M_BODY, M_WAIT} tsfc_mode_e;
  // one complete configuration image
  typedef struct packed {
    logic [15:0]      feat;
    logic             wide;
    logic             online;
    logic [3:0]       bright;
    logic [3:0]       txspd;
    logic [3:0]       rxspd;
    logic [131:0]     tabs;
    logic [19:0][7:0] msg;
    logic [4:0]       msglen;
  } tsfc_cfg_s;
  typedef struct packed {
    tsfc_mode_e mode;
    logic       page;
    logic [7:0] cur;
    tsfc_cfg_s  work;
    tsfc_cfg_s  live;
    tsfc_cfg_s  saved;
    logic [7:0] delim;
    logic [4:0] wcnt;
    logic [4:0] abidx;
    logic       ab_go;
    logic       xoff_sent;
    logic       tx_held;
    logic       hold;
    logic       f_off;
    logic       f_on;
    logic       kpend;
    logic [7:0] kchar;
    logic       txv;
    logic [7:0] txd;
    logic [7:0] rcode;
    logic [23:0] rcnt;
    logic       rarm;
    logic       rfast;
    logic       clr;
    logic       rst_req;
    logic       echov;
    logic [7:0] echoc;
  } tsfc_state_s;
endpackage : tsfc_pkg

/* hw/tsfc_top.sv */
// setup mode interpreter, auto repeat and flow control of a video terminal
//
// Local design decisions: the APB slave port and the address map.
`include "tsfc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tsfc_top #(
  parameter int RPT_DELAY_CYC = `TSFC_RPT_DELAY_MS * (`TSFC_CLK_HZ / 1000),
  parameter int RPT_PERIOD_CYC = `TSFC_CLK_HZ / `TSFC_RPT_RATE_CPS
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          srst,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // keyboard
  input  wire logic          key_valid,
  input  wire logic [7:0]    key_code,
  input  wire logic          key_shift,
  input  wire logic          key_ctrl,
  input  wire logic          key_down,
  // host serial side
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  input  wire logic [7:0]    rx_fill,
  output logic               tx_valid,
  output logic [7:0]         tx_data,
  input  wire logic          tx_ready,
  // options
  input  wire logic          opt_ext_mem,
  // display and terminal control
  output logic               setup_on,
  output logic               page_b,
  output logic [7:0]         sel_pos,
  output logic               msg_prompt,
  output logic               echo_valid,
  output logic [7:0]         echo_char,
  output logic               scr_clear,
  output logic               wait_show,
  output logic               term_reset,
  output logic               hold_screen,
  output logic [7:0]         cols,
  output logic [4:0]         rows,
  output logic [15:0]        feat_live,
  output logic               line_online,
  output logic [3:0]         bright,
  output logic [3:0]         tx_speed,
  output logic [3:0]         rx_speed,
  output logic [131:0]       tab_stops
);
  localparam logic [23:0] DLY_M1 = 24'(RPT_DELAY_CYC - 1);
  localparam logic [23:0] PER_M1 = 24'(RPT_PERIOD_CYC - 1);

  tsfc_pkg::tsfc_state_s q, d;
  logic       rfire;
  logic       ev;
  logic [7:0] c;
  logic [7:0] lc;
  logic       acc;
  logic [7:0] cmax;

  // -----------------------------------------------------------
  // key event source
  // -----------------------------------------------------------
  // held key fires
  assign rfire = ~key_valid & key_down & q.rarm & (q.rcnt == (q.rfast ? PER_M1 : DLY_M1));
  assign ev = key_valid | rfire;
  assign c = key_valid ? key_code : q.rcode;
  assign lc = c | 8'h20;  // letters case folded, shift tested apart
  assign acc = psel & penable;
  assign cmax = q.page ? 8'd15 : (q.work.wide ? 8'd131 : 8'd79);

  // -----------------------------------------------------------
  // next state
  // -----------------------------------------------------------
  always_comb begin
    d = q;
    d.clr = 1'b0;
    d.rst_req = 1'b0;
    d.echov = 1'b0;
    // repeat timer; a fresh press always restarts the slow delay
    if (key_valid) begin
      d.rcode = key_code;
      d.rcnt = '0;
      d.rfast = 1'b0;
      d.rarm = q.live.feat[`TSFC_F_AREP] & ~key_ctrl & key_code != `TSFC_K_SETUP &
               key_code != `TSFC_K_ESC & key_code != `TSFC_K_NOSCROLL &
               key_code != `TSFC_K_TAB & key_code != `TSFC_K_RET;
    end else if (!key_down) begin
      d.rarm = 1'b0;
    end else if (rfire) begin
      d.rcnt = '0;
      d.rfast = 1'b1;
    end else if (q.rarm) begin
      d.rcnt = q.rcnt + 24'h000001;
    end
    // transmitter; flow codes go out even while we are halted
    if (!q.txv || tx_ready) begin
      d.txv = 1'b0;
      if (q.f_off) begin
        d.txv = 1'b1;
        d.txd = `TSFC_XOFF;
        d.f_off = 1'b0;
        d.xoff_sent = 1'b1;
      end else if (q.f_on) begin
        d.txv = 1'b1;
        d.txd = `TSFC_XON;
        d.f_on = 1'b0;
        d.xoff_sent = 1'b0;
      end else if (!q.tx_held && q.ab_go) begin
        d.txv = q.live.msglen != 5'd0;
        d.txd = {1'b0, q.live.msg[q.abidx][6:0]};
        d.abidx = q.abidx + 5'd1;
        d.ab_go = q.abidx + 5'd1 < q.live.msglen;
      end else if (!q.tx_held && q.kpend) begin
        d.txv = 1'b1;
        d.txd = {1'b0, q.kchar[6:0]};
        d.kpend = 1'b0;
      end
    end
    // receiver: XON/XOFF honoured whatever the auto flow setting
    if (rx_valid && q.live.online) begin
      if (rx_data[6:0] == `TSFC_XOFF) d.tx_held = 1'b1;
      if (rx_data[6:0] == `TSFC_XON) d.tx_held = 1'b0;
      if (rx_data[6:0] == `TSFC_ENQ) begin
        d.ab_go = 1'b1;
        d.abidx = '0;
      end
    end
    if (q.live.feat[`TSFC_F_AXON] && rx_fill >= `TSFC_RX_NEAR_FULL && !q.xoff_sent && !q.f_off) begin
      d.f_off = 1'b1;
      d.f_on = 1'b0;
    end
    // buffer empty resumes, unless hold or setup still wants it off
    if (q.live.feat[`TSFC_F_AXON] && rx_fill == 8'h00 && q.xoff_sent && !q.f_on &&
        !q.hold && q.mode == tsfc_pkg::M_OFF && !q.f_off) begin
      d.f_on = 1'b1;
    end
    // keyboard interpreter
    case (q.mode)
      tsfc_pkg::M_OFF: begin
        if (ev) begin
          if (c == `TSFC_K_SETUP) begin
            d.mode = tsfc_pkg::M_SETUP;
            d.page = 1'b0;
            d.cur = '0;
            if (q.live.feat[`TSFC_F_AXON]) begin
              d.f_off = 1'b1;
              d.f_on = 1'b0;
            end
          end else if (c == `TSFC_K_NOSCROLL) begin
            d.hold = ~q.hold;
            if (q.live.feat[`TSFC_F_AXON]) begin
              d.f_off = ~q.hold;
              d.f_on = q.hold;
            end
          end else if (key_ctrl && c == `TSFC_K_BREAK) begin
            d.ab_go = 1'b1;
            d.abidx = '0;
          end else if (q.live.feat[`TSFC_F_AXON] && c == `TSFC_XOFF) begin
            d.f_off = 1'b1;
            d.f_on = 1'b0;
          end else if (q.live.feat[`TSFC_F_AXON] && c == `TSFC_XON) begin
            d.f_on = 1'b1;
            d.f_off = 1'b0;
          end else if (q.live.online && c < 8'h80) begin
            // a key typed while the last one still waits replaces it
            d.kpend = 1'b1;
            d.kchar = c;
          end
        end
      end
      tsfc_pkg::M_SETUP: begin
        if (ev) begin
          if (c == `TSFC_K_SETUP) begin
            d.mode = tsfc_pkg::M_OFF;
            d.live = q.work;
            d.clr = q.work.wide != q.live.wide;
            if (q.work.feat[`TSFC_F_AXON] && !q.hold) begin
              d.f_on = 1'b1;
              d.f_off = 1'b0;
            end
          end else if (key_shift && lc == 8'h73) begin
            d.saved = q.work;
            d.clr = 1'b1;
            d.mode = tsfc_pkg::M_WAIT;
            d.wcnt = '0;
          end else if (key_shift && lc == 8'h72) begin
            d.work = q.saved;
            d.live = q.saved;
            d.clr = 1'b1;
            d.mode = tsfc_pkg::M_WAIT;
            d.wcnt = '0;
          end else if (!key_shift && lc == 8'h6F) begin
            d.work = q.saved;
            d.live = q.saved;
            d.clr = 1'b1;
            d.rst_req = 1'b1;
            d.mode = tsfc_pkg::M_OFF;
            d.hold = 1'b0;
            d.tx_held = 1'b0;
          end else if (c == 8'h35) begin
            d.page = ~q.page;
            d.cur = '0;
          end else if (c == `TSFC_K_SPACE || c == `TSFC_K_RIGHT) begin
            d.cur = q.cur < cmax ? q.cur + 8'd1 : q.cur;
          end else if (c == `TSFC_K_LEFT) begin
            d.cur = q.cur != 8'd0 ? q.cur - 8'd1 : q.cur;
          end else if (c == `TSFC_K_TAB) begin
            d.cur = q.cur + 8'd8 <= cmax ? q.cur + 8'd8 : cmax;
          end else if (c == `TSFC_K_RET) begin
            d.cur = '0;
          end else if (c == 8'h36) begin
            if (q.page) d.work.feat[q.cur[3:0]] = ~q.work.feat[q.cur[3:0]];
            else d.work.tabs[q.cur] = ~q.work.tabs[q.cur];
          end else if (!q.page) begin
            if (c == 8'h39) d.work.wide = ~q.work.wide;
            if (c == 8'h34) d.work.online = ~q.work.online;
            if (c == 8'h33) d.work.tabs = '0;
            if (c == `TSFC_K_UP && q.work.bright != 4'hF) d.work.bright = q.work.bright + 4'h1;
            if (c == `TSFC_K_DOWN && q.work.bright != 4'h0) d.work.bright = q.work.bright - 4'h1;
          end else begin
            if (c == 8'h37) d.work.txspd = q.work.txspd + 4'h1;
            if (c == 8'h38) d.work.rxspd = q.work.rxspd + 4'h1;
            if (key_shift && lc == 8'h61) d.mode = tsfc_pkg::M_DELIM;
          end
        end
      end
      tsfc_pkg::M_DELIM: begin
        if (ev) begin
          d.delim = c;
          d.work.msglen = '0;
          d.mode = tsfc_pkg::M_BODY;
        end
      end
      tsfc_pkg::M_BODY: begin
        if (ev) begin
          if (c == q.delim) begin
            d.mode = tsfc_pkg::M_SETUP;
          end else if (q.work.msglen < `TSFC_MSG_MAX) begin
            // any char stored, controls shown as glyph
            d.work.msg[q.work.msglen] = c;
            d.work.msglen = q.work.msglen + 5'd1;
            d.echov = 1'b1;
            d.echoc = (c < 8'h20 || c == 8'h7F) ? `TSFC_GLYPH : c;
          end
        end
      end
      tsfc_pkg::M_WAIT: begin
        d.wcnt = q.wcnt + 5'd1;
        if (q.wcnt == 5'(`TSFC_WAIT_CYC - 1)) begin
          d.mode = tsfc_pkg::M_SETUP;
          d.page = 1'b0;
          d.cur = '0;
        end
      end
      default: d.mode = tsfc_pkg::M_OFF;
    endcase
    if (acc && pwrite && paddr == `TSFC_OFF_CTRL) begin
      d.live.feat[2:0] = pwdata[2:0];
      d.live.wide = pwdata[`TSFC_C_WIDE];
      d.live.online = pwdata[`TSFC_C_ONLINE];
      d.work.feat[2:0] = pwdata[2:0];
      d.work.wide = pwdata[`TSFC_C_WIDE];
      d.work.online = pwdata[`TSFC_C_ONLINE];
      d.clr = d.clr | (pwdata[`TSFC_C_WIDE] != q.live.wide);
    end
    // power-up image
    if (srst) begin
      d = '0;
      d.mode = tsfc_pkg::M_OFF;
      d.work.online = 1'b1;
      d.work.bright = `TSFC_RST_BRIGHT;
      d.work.txspd = `TSFC_RST_SPEED;
      d.work.rxspd = `TSFC_RST_SPEED;
      d.live = d.work;
      d.saved = d.work;
    end
  end

  // -----------------------------------------------------------
  // state register
  // -----------------------------------------------------------
  always_ff @(posedge clock) begin
    q <= d;
  end

  // -----------------------------------------------------------
  // apb read side and outputs
  // -----------------------------------------------------------
  always_comb begin
    prdata = '0;
    if (acc && !pwrite && paddr == `TSFC_OFF_CTRL)
      prdata = {27'h0, q.live.online, q.live.wide, q.live.feat[2:0]};
    if (acc && !pwrite && paddr == `TSFC_OFF_STATUS)
      prdata = {16'h0, q.cur, 3'h0, q.mode == tsfc_pkg::M_BODY, q.tx_held, q.xoff_sent,
                q.page, q.mode != tsfc_pkg::M_OFF};
  end
  assign pready = 1'b1;
  assign pslverr = acc && paddr != `TSFC_OFF_CTRL && paddr != `TSFC_OFF_STATUS;
  assign tx_valid = q.txv;
  assign tx_data = q.txd;
  assign setup_on = q.mode != tsfc_pkg::M_OFF;
  assign page_b = q.page;
  assign sel_pos = q.cur;
  assign msg_prompt = q.mode == tsfc_pkg::M_DELIM || q.mode == tsfc_pkg::M_BODY;
  assign echo_valid = q.echov;
  assign echo_char = q.echoc;
  assign scr_clear = q.clr;
  assign wait_show = q.mode == tsfc_pkg::M_WAIT;
  assign term_reset = q.rst_req;
  assign hold_screen = q.hold;
  assign cols = q.live.wide ? `TSFC_COLS_W : `TSFC_COLS_N;
  assign rows = (q.live.wide && !opt_ext_mem) ? `TSFC_ROWS_W : `TSFC_ROWS_F;
  assign feat_live = q.live.feat;
  assign line_online = q.live.online;
  assign bright = q.live.bright;
  assign tx_speed = q.live.txspd;
  assign rx_speed = q.live.rxspd;
  assign tab_stops = q.live.tabs;

  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  a_page_flip: assert property (@(posedge clock) disable iff (srst)
    ev && q.mode == tsfc_pkg::M_SETUP && c == 8'h35 |=> page_b != $past(page_b))
    else $error("page did not flip");
  a_wait_return: assert property (@(posedge clock) disable iff (srst)
    $rose(wait_show) |-> wait_show [*8] ##1 wait_show [*8] ##1 (setup_on && !page_b && !wait_show))
    else $error("wait phase length wrong");
  a_save_image: assert property (@(posedge clock) disable iff (srst)
    ev && q.mode == tsfc_pkg::M_SETUP && key_shift && lc == 8'h73 |=> q.saved == $past(q.work) && scr_clear)
    else $error("save did not copy image");
  a_recall_image: assert property (@(posedge clock) disable iff (srst)
    ev && q.mode == tsfc_pkg::M_SETUP && key_shift && lc == 8'h72 |=> q.live == q.saved && q.work == q.saved)
    else $error("recall did not restore");
  a_msg_store: assert property (@(posedge clock) disable iff (srst)
    ev && q.mode == tsfc_pkg::M_BODY && c != q.delim && q.work.msglen < 5'd20
    |=> q.work.msglen == $past(q.work.msglen) + 5'd1 && echo_valid)
    else $error("message char not stored");
  a_xoff_halt: assert property (@(posedge clock) disable iff (srst)
    q.tx_held && (!tx_valid || tx_ready) |=> !tx_valid || tx_data == 8'h11 || tx_data == 8'h13)
    else $error("halt not taken");
  a_tx_bit8: assert property (@(posedge clock) disable iff (srst)
    tx_valid |-> !tx_data[7])
    else $error("bit 8 sent nonzero");
  a_setup_xoff: assert property (@(posedge clock) disable iff (srst)
    key_valid && key_code == 8'h80 && q.mode == tsfc_pkg::M_OFF && q.live.feat[0] && !q.xoff_sent
    |-> ##[1:3] (tx_valid && tx_data == 8'h13))
    else $error("no xoff on setup entry");
  a_width_clear: assert property (@(posedge clock) disable iff (srst)
    ev && q.mode == tsfc_pkg::M_SETUP && c == 8'h80 && q.work.wide != q.live.wide |=> scr_clear && $changed(cols))
    else $error("width change kept screen");
  a_geometry: assert property (@(posedge clock) disable iff (srst)
    rows == ((cols == 8'd132 && !opt_ext_mem) ? 5'd14 : 5'd24))
    else $error("rows do not match width");
endmodule : tsfc_top
`default_nettype wire

/* dv/tsfc_host_model.sv */
// host computer model on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
module tsfc_host_model (
  // clock
  input  wire logic       clock,
  // serial link toward the terminal
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic [7:0]      rx_fill
);
  logic [7:0] got[$];
  logic       slow = 1'h0;
  logic       pend = 1'h0;
  logic [7:0] pbyte = 8'h00;
  // idle link, empty buffer
  initial begin
    tx_ready = 1'h1;
    rx_valid = 1'h0;
    rx_data = 8'h00;
    rx_fill = 8'h00;
  end
  // collect bytes; slow mode stalls every other cycle
  // idle data line toggles so a stale byte never looks valid
  always @(posedge clock) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'h1;
    rx_valid <= pend;
    rx_data <= pend ? pbyte : ~rx_data;
  end
  // one received byte, launched at the next edge
  task automatic send(input logic [7:0] b);
    pbyte <= b;
    pend <= 1'h1;
    @(posedge clock);
    pend <= 1'h0;
  endtask : send
endmodule : tsfc_host_model
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the setup and flow control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00, key_code = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e;
  logic key_valid = 1'h0, key_shift = 1'h0, key_ctrl = 1'h0, key_down = 1'h0;
  logic opt_ext_mem = 1'h0;
  logic rx_valid, tx_valid, tx_ready, setup_on, page_b, msg_prompt;
  logic echo_valid, scr_clear, wait_show;
  logic [7:0] rx_data, rx_fill, tx_data, echo_char, cols, sel_pos;
  logic [4:0] rows;
  logic term_reset, hold_screen;
  logic [131:0] tab_stops;
  int err_count = 0;
  int samples_checked = 0;
  // short repeat counts keep the run brief
  tsfc_top #(.RPT_DELAY_CYC(20), .RPT_PERIOD_CYC(5)) dut (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_valid(key_valid), .key_code(key_code), .key_shift(key_shift), .key_ctrl(key_ctrl),
    .key_down(key_down), .rx_valid(rx_valid), .rx_data(rx_data), .rx_fill(rx_fill),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .opt_ext_mem(opt_ext_mem),
    .setup_on(setup_on), .page_b(page_b), .sel_pos(sel_pos), .msg_prompt(msg_prompt),
    .echo_valid(echo_valid), .echo_char(echo_char), .scr_clear(scr_clear),
    .wait_show(wait_show), .term_reset(term_reset), .hold_screen(hold_screen), .cols(cols), .rows(rows),
    .feat_live(), .line_online(), .bright(), .tx_speed(), .rx_speed(), .tab_stops(tab_stops));
  tsfc_host_model host (.clock(clock), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_fill(rx_fill));
  // 25 MHz clock
  always #20 clock = ~clock;
  // ----
  // common tasks
  // ----
  task automatic end_of_test;
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic hang;
    err_count++;
    end_of_test();
  endtask : hang
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // apb transfer, request held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) hang();
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask : apb
  // one key press; result sampled one edge later
  task automatic key(input logic [7:0] c, input logic s, input logic d);
    key_valid <= 1'h1;
    key_code <= c;
    key_shift <= s;
    key_down <= d;
    @(posedge clock);
    key_valid <= 1'h0;
    @(posedge clock);
  endtask : key
  task automatic wait_tx(input int k);
    int n;
    for (n = 0; n < 200 && host.got.size() < k; n++) @(posedge clock);
    if (n >= 200) hang();
  endtask : wait_tx
  // ----
  // scenarios
  // ----
  task automatic t_geom;
    chk(cols, 8'h50);
    chk(rows, 5'h18);
    apb(1'h1, 8'h00, 32'h19);
    chk(cols, 8'h84);
    chk(rows, 5'h0E);
    opt_ext_mem <= 1'h1;
    repeat (2) @(posedge clock);
    chk(rows, 5'h18);
    apb(1'h0, 8'h08, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask : t_geom
  task automatic t_flow;
    host.got.delete();
    key(8'h80, 1'h0, 1'h0);
    wait_tx(1);
    chk(host.got[0], 8'h13);
    key(8'h35, 1'h0, 1'h0);
    chk({setup_on, page_b}, 2'h3);
    key(8'h39, 1'h0, 1'h0);
    key(8'h35, 1'h0, 1'h0);
    chk(page_b, 1'h0);
    key(8'h82, 1'h0, 1'h0);
    key(8'h09, 1'h0, 1'h0);
    chk(sel_pos, 8'h09);
    key(8'h36, 1'h0, 1'h0);
    key(8'h39, 1'h0, 1'h0);
    key(8'h80, 1'h0, 1'h0);
    chk(scr_clear, 1'h1);
    chk(cols, 8'h50);
    chk(tab_stops[31:0], 32'h200);
    wait_tx(2);
    chk(host.got[1], 8'h11);
    key(8'h85, 1'h0, 1'h0);
    chk(hold_screen, 1'h1);
    wait_tx(3);
    chk(host.got[2], 8'h13);
    key(8'h85, 1'h0, 1'h0);
    wait_tx(4);
    chk(host.got[3], 8'h11);
  endtask : t_flow
  task automatic t_halt;
    host.got.delete();
    host.send(8'h13);
    repeat (3) @(posedge clock);
    key(8'h78, 1'h0, 1'h0);
    repeat (20) @(posedge clock);
    chk(host.got.size(), 0);
    host.send(8'h11);
    wait_tx(1);
    chk(host.got[0], 8'h78);
  endtask : t_halt
  task automatic t_msg;
    key(8'h80, 1'h0, 1'h0);
    key(8'h35, 1'h0, 1'h0);
    key(8'h41, 1'h1, 1'h0);
    chk(msg_prompt, 1'h1);
    key(8'h2F, 1'h0, 1'h0);
    chk(echo_valid, 1'h0);
    key(8'h68, 1'h0, 1'h0);
    chk({echo_valid, echo_char}, 9'h168);
    key(8'h01, 1'h0, 1'h0);
    chk({echo_valid, echo_char}, 9'h1B0);
    key(8'h2F, 1'h0, 1'h0);
    chk(msg_prompt, 1'h0);
    key(8'h80, 1'h0, 1'h0);
    repeat (8) @(posedge clock);
    host.got.delete();
    host.slow <= 1'h1;
    host.send(8'h05);
    wait_tx(2);
    chk({host.got[0], host.got[1]}, 16'h6801);
    host.got.delete();
    key_ctrl <= 1'h1;
    key(8'h86, 1'h0, 1'h0);
    key_ctrl <= 1'h0;
    wait_tx(2);
    chk({host.got[0], host.got[1]}, 16'h6801);
    host.slow <= 1'h0;
  endtask : t_msg
  // save or recall, then leave setup and look at the width
  task automatic t_wait(input logic [7:0] c, input logic [7:0] ec);
    int n;
    key(8'h80, 1'h0, 1'h0);
    key(c, 1'h1, 1'h0);
    chk({scr_clear, wait_show}, 2'h3);
    for (n = 0; n < 40 && wait_show === 1'h1; n++) @(posedge clock);
    chk(n, 16);
    chk({setup_on, page_b}, 2'h2);
    key(8'h80, 1'h0, 1'h0);
    chk(cols, ec);
  endtask : t_wait
  // keyboard reset from setup mode
  task automatic t_reset;
    key(8'h80, 1'h0, 1'h0);
    key(8'h6F, 1'h0, 1'h0);
    chk({term_reset, setup_on}, 2'h2);
  endtask : t_reset
  // held key: at least lo and at most hi bytes reach the host
  task automatic t_rpt(input logic [7:0] c, input int lo, input int hi);
    host.got.delete();
    key(c, 1'h0, 1'h1);
    repeat (40) @(posedge clock);
    key_down <= 1'h0;
    repeat (6) @(posedge clock);
    chk(host.got.size() >= lo, 1'h1);
    chk(host.got.size() <= hi, 1'h1);
  endtask : t_rpt
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    t_geom();
    t_flow();
    t_halt();
    t_msg();
    apb(1'h1, 8'h00, 32'h19);
    t_wait(8'h52, 8'h50);
    apb(1'h1, 8'h00, 32'h19);
    t_wait(8'h53, 8'h84);
    t_wait(8'h52, 8'h84);
    t_reset();
    apb(1'h1, 8'h00, 32'h12);
    t_rpt(8'h7A, 3, 8);
    t_rpt(8'h09, 1, 1);
    key_ctrl <= 1'h1;
    t_rpt(8'h7A, 1, 1);
    key_ctrl <= 1'h0;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
